// >>> src/mac_pace_pkg.sv
// constants and helpers for the pacing, pause and address filter block
package mac_pace_pkg;
  // register byte offsets
  localparam logic [7:0]  OFS_PACE   = 8'h00; // pacing observe
  localparam logic [7:0]  OFS_RXP    = 8'h04; // receive pause countdown
  localparam logic [7:0]  OFS_TXP    = 8'h08; // transmit pause countdown
  localparam logic [7:0]  OFS_INDEX  = 8'h0C; // address slot index
  localparam logic [7:0]  OFS_HI     = 8'h10; // address high word
  localparam logic [7:0]  OFS_LO     = 8'h14; // address entry low word
  localparam logic [7:0]  OFS_CTRL   = 8'h18; // link speed select
  // widths and sizes
  localparam int          PACE_W     = 5;     // pacing counter width
  localparam int          IDX_W      = 5;     // slot index width
  localparam int          ENTRIES    = 32;    // address ram depth
  localparam int          ENTRY_W    = 53;    // committed entry width
  localparam int          CH_W       = 3;     // channel field width
  // reset and load values
  localparam logic [4:0]  PACE_RELOAD = 5'h1F; // pacing reload
  localparam logic [15:0] RXP_LOAD    = 16'hFF00; // rx pause reload
  localparam logic [15:0] PAUSE_MAX   = 16'hFFFF; // sent pause time
  localparam logic [1:0]  SPD_10     = 2'h0;  // 10 Mb/s
  localparam logic [1:0]  SPD_100    = 2'h1;  // 100 Mb/s
  localparam logic [1:0]  SPD_1000   = 2'h2;  // 1000 Mb/s
  localparam logic [1:0]  CTRL_RESET = SPD_1000; // speed after reset
  // low word fields
  localparam int          LO_VALID   = 20;    // valid flag
  localparam int          LO_MF      = 19;    // match or reject select
  localparam int          LO_CH_LSB  = 16;    // channel field base
  localparam int          LO_USED_W  = 21;    // used low word bits
  // entry layout: valid, select, channel, 48-bit address
  localparam int          E_VALID    = 52;    // entry valid bit
  localparam int          E_MF       = 51;    // entry select bit
  localparam int          E_CH_LSB   = 48;    // entry channel base
  // slot time, derived from bit time and clock period
  localparam int          CLK_NS     = 8;     // clock period in ns
  localparam int          SLOT_BITS  = 512;   // bit times per slot
  localparam int          BIT_NS_1G  = 1;     // bit time at 1000 Mb/s
  localparam int          BIT_NS_100 = 10;    // bit time at 100 Mb/s
  localparam int          BIT_NS_10  = 100;   // bit time at 10 Mb/s
  localparam int SLOT_CYC_1G  = SLOT_BITS * BIT_NS_1G / CLK_NS;
  localparam int SLOT_CYC_100 = SLOT_BITS * BIT_NS_100 / CLK_NS;
  localparam int SLOT_CYC_10  = SLOT_BITS * BIT_NS_10 / CLK_NS;
  localparam int SLOT_CNT_W   = 13;           // slot counter width

  // byte 0 sits in bits 15-8 of the low word, byte 1 in bits 7-0
  function automatic logic [47:0] addr_join(input logic [31:0] hi,
                                            input logic [15:0] lo);
    addr_join = {hi[7:0], hi[15:8], hi[23:16], hi[31:24],
                 lo[7:0], lo[15:8]};
  endfunction : addr_join
endpackage : mac_pace_pkg

// >>> src/slot_tick_gen.sv
// slot time tick divider, 512 bit times at the selected speed
`timescale 1ns/1ps
module slot_tick_gen
  import mac_pace_pkg::*;
#(
  parameter int SLOW_CYC = SLOT_CYC_10     // cycles per slot at 10 Mb/s
) (
  input  wire logic       i_clock,         // core clock
  input  wire logic       i_rst,           // sync reset, high
  input  wire logic [1:0] i_speed,         // link speed select
  output logic            o_tick           // one-cycle slot pulse
);
  logic [SLOT_CNT_W-1:0] cnt_reg;          // cycles into slot
  logic [SLOT_CNT_W-1:0] last;             // terminal count
  wire                   wrap = (cnt_reg >= last); // slot done

  // terminal count for the current speed
  assign last = (i_speed == SPD_10)  ? SLOT_CNT_W'(SLOW_CYC - 1) :
                (i_speed == SPD_100) ? SLOT_CNT_W'(SLOT_CYC_100 - 1) :
                                       SLOT_CNT_W'(SLOT_CYC_1G - 1);

  // free running counter, pulse on wrap
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      o_tick  <= wrap;
    end
  end
endmodule : slot_tick_gen

// >>> src/addr_ram.sv
// receive address ram with write commit and match lookup
`timescale 1ns/1ps
module addr_ram
  import mac_pace_pkg::*;
(
  input  wire logic               i_clock,   // core clock
  input  wire logic               i_rst,     // sync reset, high
  input  wire logic               i_we,      // commit entry
  input  wire logic [IDX_W-1:0]   i_index,   // entry index
  input  wire logic [31:0]        i_hi,      // staged high word
  input  wire logic [31:0]        i_lo,      // low word being written
  output logic      [31:0]        o_lo_rd,   // low word of indexed entry
  input  wire logic [47:0]        i_look,    // destination to look up
  output logic                    o_hit,     // valid entry equal
  output logic                    o_accept,  // hit is a match entry
  output logic      [CH_W-1:0]    o_channel  // channel of match
);
  logic [ENTRY_W-1:0] mem [ENTRIES];         // committed entries
  logic [ENTRY_W-1:0] rd;                    // indexed entry

  // all 53 bits land together when the low word is written
  // commit whole entry
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < ENTRIES; i++) mem[i] <= '0;
    end else if (i_we) begin
      mem[i_index] <= {i_lo[LO_VALID], i_lo[LO_MF],
                       i_lo[LO_CH_LSB +: CH_W], addr_join(i_hi, i_lo[15:0])};
    end
  end

  // read back in low word layout
  assign rd = mem[i_index];
  // byte 0 high, byte 1 low
  assign o_lo_rd = {11'h0, rd[E_VALID], rd[E_MF], rd[E_CH_LSB +: CH_W],
                    rd[7:0], rd[15:8]};

  // lowest valid equal entry wins; invalid entries never take part
  // valid gates matching
  always_comb begin
    o_hit     = 1'b0;
    o_accept  = 1'b0;
    o_channel = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (mem[i][E_VALID] && mem[i][47:0] == i_look) begin
        o_hit     = 1'b1;
        o_accept  = mem[i][E_MF];
        o_channel = mem[i][E_MF] ? mem[i][E_CH_LSB +: CH_W] : '0;
      end
    end
  end
endmodule : addr_ram

// >>> src/mac_pace_top.sv
// pacing, pause timers and address filter with apb registers
// Operation
// - 5-bit pacing counter readable, nonzero means active
// - collision or deferral reloads pacing with 31
// - clean frame decrements pacing, stops at zero
// - pacing active, clean frame: four-gap wait
// - deferred or collided frame: normal gap
// - sent pause 0xFFFF loads rx countdown 0xFF00
// - rx countdown decrements per slot, readable
// - rx countdown zero requests another pause frame
// - received pause loads tx countdown
// - tx countdown per slot; transmit resumes at zero
// - entry bit 20 valid, invalid entries ignored
// - bit 19 selects match or filter
// - matching entry selects channel, else ignored
// - low word holds byte 0 high, byte 1 low
// - whole entry committed on low word write
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module mac_pace_top
  import mac_pace_pkg::*;
#(
  parameter int SLOT_CYC_SLOW = SLOT_CYC_10 // slot cycles at 10 Mb/s
) (
  input  wire logic        i_clock,          // 125 MHz core clock
  input  wire logic        i_rst,            // sync reset, high
  input  wire logic        i_psel,           // apb select
  input  wire logic        i_penable,        // apb enable
  input  wire logic        i_pwrite,         // apb write
  input  wire logic [7:0]  i_paddr,          // apb byte address
  input  wire logic [31:0] i_pwdata,         // apb write data
  output logic      [31:0] o_prdata,         // apb read data
  output logic             o_pready,         // apb ready
  output logic             o_pslverr,        // apb error, unmapped
  input  wire logic        i_tx_done,        // frame transmit finished
  input  wire logic        i_tx_collided,    // that frame collided
  input  wire logic        i_tx_deferred,    // that frame was deferred
  input  wire logic        i_pause_sent,     // pause frame sent
  input  wire logic [15:0] i_pause_sent_time, // its pause time
  input  wire logic        i_pause_rcvd,     // pause frame received
  input  wire logic [15:0] i_pause_rcvd_time, // its pause time
  input  wire logic        i_rx_addr_stb,    // destination valid
  input  wire logic [47:0] i_rx_dest_addr,   // received destination
  output logic             o_long_gap,       // use four gaps next
  output logic             o_pacing_active,  // pacing count nonzero
  output logic             o_tx_enable,      // tx pause expired
  output logic             o_send_pause,     // request a pause frame
  output logic             o_rx_valid,       // lookup result pulse
  output logic             o_rx_hit,         // valid entry equal
  output logic             o_rx_accept,      // hit entry is a match
  output logic [CH_W-1:0]  o_rx_channel      // receive channel
);
  // register state
  logic [PACE_W-1:0] pace_reg;               // pacing counter
  logic [PACE_W-1:0] pace_next;              // its next value
  logic [15:0]       rxp_reg;                // rx pause countdown
  logic [15:0]       rxp_next;               // its next value
  logic [15:0]       txp_reg;                // tx pause countdown
  logic [15:0]       txp_next;               // its next value
  logic [IDX_W-1:0]  index_reg;              // address slot index
  logic [31:0]       hi_reg;                 // staged high word
  logic [1:0]        speed_reg;              // link speed select
  logic [31:0]       rd_mux;                 // read data select
  logic [31:0]       lo_rd;                  // indexed low word
  logic              tick;                   // slot time pulse
  logic              hit;                    // lookup hit
  logic              accept;                 // lookup accept
  logic [CH_W-1:0]   channel;                // lookup channel

  // apb decode
  wire setup   = i_psel & ~i_penable;        // setup phase
  wire wr_fire = i_psel & i_penable & o_pready & i_pwrite; // write edge
  wire mapped  = (i_paddr == OFS_PACE) | (i_paddr == OFS_RXP) |
                 (i_paddr == OFS_TXP)  | (i_paddr == OFS_INDEX) |
                 (i_paddr == OFS_HI)   | (i_paddr == OFS_LO) |
                 (i_paddr == OFS_CTRL);
  wire wr_rxp  = wr_fire & (i_paddr == OFS_RXP);   // rx pause write
  wire wr_txp  = wr_fire & (i_paddr == OFS_TXP);   // tx pause write
  wire wr_idx  = wr_fire & (i_paddr == OFS_INDEX); // index write
  wire wr_hi   = wr_fire & (i_paddr == OFS_HI);    // high word write
  wire wr_lo   = wr_fire & (i_paddr == OFS_LO);    // low word write
  wire wr_ctrl = wr_fire & (i_paddr == OFS_CTRL);  // speed write

  // frame outcome decode
  wire tx_bad   = i_tx_done & (i_tx_collided | i_tx_deferred); // hit frame
  wire tx_clean = i_tx_done & ~i_tx_collided & ~i_tx_deferred; // good one
  wire pace_nz  = (pace_reg != '0);          // pacing active now
  wire rx_load  = i_pause_sent & (i_pause_sent_time == PAUSE_MAX);

  // read data select, reserved bits read zero
  // pacing counter visible
  assign rd_mux =
    (i_paddr == OFS_PACE)  ? {27'h0, pace_reg} :
    (i_paddr == OFS_RXP)   ? {16'h0000, rxp_reg} :
    (i_paddr == OFS_TXP)   ? {16'h0000, txp_reg} :
    (i_paddr == OFS_INDEX) ? {27'h0, index_reg} :
    (i_paddr == OFS_HI)    ? hi_reg :
    (i_paddr == OFS_LO)    ? lo_rd :
    (i_paddr == OFS_CTRL)  ? {30'h0, speed_reg} : 32'h00000000;

  // clean frame counts down to zero
  assign pace_next = tx_bad ? PACE_RELOAD :
                     (tx_clean && pace_nz) ? pace_reg - 1'b1 : pace_reg;

  assign rxp_next = rx_load ? RXP_LOAD :
                    wr_rxp  ? i_pwdata[15:0] :
                    (tick && rxp_reg != '0) ? rxp_reg - 1'b1 : rxp_reg;

  assign txp_next = i_pause_rcvd ? i_pause_rcvd_time :
                    wr_txp ? i_pwdata[15:0] :
                    (tick && txp_reg != '0) ? txp_reg - 1'b1 : txp_reg;

  slot_tick_gen #(
    .SLOW_CYC (SLOT_CYC_SLOW)
  ) u_tick (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_speed (speed_reg),
    .o_tick  (tick)
  );

  addr_ram u_ram (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_we      (wr_lo),
    .i_index   (index_reg),
    .i_hi      (hi_reg),
    .i_lo      (i_pwdata),
    .o_lo_rd   (lo_rd),
    .i_look    (i_rx_dest_addr),
    .o_hit     (hit),
    .o_accept  (accept),
    .o_channel (channel)
  );

  // apb answer: ready in the first access cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~mapped;
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // software staged registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      index_reg <= '0;
      hi_reg    <= '0;
      speed_reg <= CTRL_RESET;
    end else begin
      if (wr_idx)  index_reg <= i_pwdata[IDX_W-1:0];
      if (wr_hi)   hi_reg    <= i_pwdata;
      if (wr_ctrl) speed_reg <= i_pwdata[1:0];
    end
  end

  // counters
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pace_reg <= '0;
      rxp_reg  <= '0;
      txp_reg  <= '0;
    end else begin
      pace_reg <= pace_next;
      rxp_reg  <= rxp_next;
      txp_reg  <= txp_next;
    end
  end

  // gap choice held from one frame end to the next
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_long_gap <= 1'b0;
    end else if (i_tx_done) begin
      o_long_gap <= tx_clean & pace_nz;
    end
  end

  // status outputs
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pacing_active <= 1'b0;
      o_tx_enable     <= 1'b1;
      o_send_pause    <= 1'b0;
    end else begin
      o_pacing_active <= (pace_next != '0);
      o_tx_enable     <= (txp_next == '0);
      o_send_pause    <= tick & (rxp_reg == 16'h0001) & ~rx_load & ~wr_rxp;
    end
  end

  // address lookup result, one cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rx_valid   <= 1'b0;
      o_rx_hit     <= 1'b0;
      o_rx_accept  <= 1'b0;
      o_rx_channel <= '0;
    end else begin
      o_rx_valid <= i_rx_addr_stb;
      if (i_rx_addr_stb) begin
        o_rx_hit     <= hit;
        o_rx_accept  <= accept;
        o_rx_channel <= channel;
      end
    end
  end

  // checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence clean_frame;
    i_tx_done && !i_tx_collided && !i_tx_deferred;
  endsequence
  sequence bad_frame;
    i_tx_done && (i_tx_collided || i_tx_deferred);
  endsequence
  sequence no_rx_load;
    !rx_load && !wr_rxp;
  endsequence

  AST_PACE_RELOAD: assert property (
    bad_frame |=> pace_reg == 5'h1F ##1 o_pacing_active)
    else $error("pacing not reloaded");
  AST_PACE_DEC: assert property (
    clean_frame ##0 pace_nz |=> pace_reg == $past(pace_reg) - 5'h01)
    else $error("pacing not decremented");
  AST_LONG_GAP: assert property (
    clean_frame ##0 pace_nz |=> o_long_gap)
    else $error("long gap missing");
  AST_NORMAL_GAP: assert property (
    bad_frame |=> !o_long_gap)
    else $error("gap stretched after bad frame");
  AST_RXP_LOAD: assert property (
    rx_load |=> rxp_reg == 16'hFF00)
    else $error("rx pause not loaded");
  AST_RXP_HOLD: assert property (
    !tick ##0 no_rx_load |=> $stable(rxp_reg))
    else $error("rx pause moved off tick");
  AST_PAUSE_REQ: assert property (
    tick && rxp_reg == 16'h0001 ##0 no_rx_load
      |=> o_send_pause && rxp_reg == 16'h0000)
    else $error("pause request missing");
  AST_TXP_LOAD: assert property (
    i_pause_rcvd |=> txp_reg == $past(i_pause_rcvd_time))
    else $error("tx pause not loaded");
  AST_TX_EN: assert property (
    o_tx_enable == (txp_reg == 16'h0000))
    else $error("tx enable wrong");

  // counter steps, pulse widths and lookup result shape
  sequence no_tx_load;
    !i_pause_rcvd && !wr_txp;
  endsequence

  AST_PACE_FLOOR: assert property (
    clean_frame ##0 !pace_nz |=> pace_reg == 5'h00)
    else $error("pacing went below zero");
  AST_PACE_ACTIVE: assert property (
    o_pacing_active == pace_nz)
    else $error("pacing active flag wrong");
  AST_RXP_DEC: assert property (
    tick && rxp_reg != 16'h0000 ##0 no_rx_load
      |=> rxp_reg == $past(rxp_reg) - 16'h0001)
    else $error("rx pause not decremented");
  AST_SEND_ONCE: assert property (
    o_send_pause |=> !o_send_pause)
    else $error("pause request longer than one cycle");
  AST_TXP_DEC: assert property (
    tick && txp_reg != 16'h0000 ##0 no_tx_load
      |=> txp_reg == $past(txp_reg) - 16'h0001)
    else $error("tx pause not decremented");
  AST_TXP_HOLD: assert property (
    !tick ##0 no_tx_load |=> $stable(txp_reg))
    else $error("tx pause moved off tick");
  AST_RX_CHANNEL: assert property (
    o_rx_valid && !o_rx_accept |-> o_rx_channel == 3'h0)
    else $error("channel shown for filter entry");
  AST_TICK_PULSE: assert property (
    tick |=> !tick)
    else $error("slot tick longer than one cycle");
endmodule : mac_pace_top

// >>> tb/link_peer_model.sv
// link partner stand-in: frame outcomes, pause frames, destinations
`timescale 1ns/1ps
module link_peer_model (
  input  wire logic   i_clock,      // core clock
  output logic        o_tx_done,    // frame transmit finished
  output logic        o_collided,   // that frame collided
  output logic        o_deferred,   // that frame was deferred
  output logic        o_pause_sent, // our pause frame went out
  output logic [15:0] o_sent_time,  // its pause time
  output logic        o_pause_rcvd, // peer pause frame arrived
  output logic [15:0] o_rcvd_time,  // its pause time
  output logic        o_addr_stb,   // destination valid
  output logic [47:0] o_dest        // received destination
);
  // quiet line at time zero
  initial begin
    {o_tx_done, o_collided, o_deferred} = 3'h0;
    {o_pause_sent, o_pause_rcvd, o_addr_stb} = 3'h0;
    o_sent_time = 16'h0000;
    o_rcvd_time = 16'h0000;
    o_dest = 48'h0;
  end
  // one frame ends; qualifiers turn to junk once released
  task automatic frame(input logic coll, input logic dfr);
    @(posedge i_clock);
    {o_tx_done, o_collided, o_deferred} <= {1'b1, coll, dfr};
    @(posedge i_clock);
    {o_tx_done, o_collided, o_deferred} <= {1'b0, ~coll, ~dfr};
  endtask : frame
  // our own pause frame leaves with time t
  task automatic sent(input logic [15:0] t);
    @(posedge i_clock);
    {o_pause_sent, o_sent_time} <= {1'b1, t};
    @(posedge i_clock);
    {o_pause_sent, o_sent_time} <= {1'b0, ~t};
  endtask : sent
  // peer pause frame arrives with time t
  task automatic rcvd(input logic [15:0] t);
    @(posedge i_clock);
    {o_pause_rcvd, o_rcvd_time} <= {1'b1, t};
    @(posedge i_clock);
    {o_pause_rcvd, o_rcvd_time} <= {1'b0, ~t};
  endtask : rcvd
  // a frame destination is presented for one cycle
  task automatic dest(input logic [47:0] a);
    @(posedge i_clock);
    {o_addr_stb, o_dest} <= {1'b1, a};
    @(posedge i_clock);
    {o_addr_stb, o_dest} <= {1'b0, ~a};
  endtask : dest
endmodule : link_peer_model

// >>> tb/mac_pace_top_tb.sv
// self-checking bench for the pacing, pause and address filter block
`timescale 1ns/1ps
module mac_pace_top_tb;
  import mac_pace_pkg::*;
  localparam int SLOW = 100;   // shortened 10 Mb/s slot
  logic        i_clock;        // core clock
  logic        i_rst;          // sync reset
  logic        psel;           // apb select
  logic        penable;        // apb enable
  logic        pwrite;         // apb direction
  logic [7:0]  paddr;          // apb address
  logic [31:0] pwdata;         // apb write data
  logic [31:0] prdata;         // apb read data
  logic        pready;         // apb ready
  logic        pslverr;        // apb error
  logic        td, tc, tf, ps, pr, st; // partner strobes
  logic [15:0] pst, prt;       // pause times
  logic [47:0] da;             // destination
  logic        lg, pa, te, sp, rv, rh, ra; // block status
  logic [2:0]  rc;             // receive channel
  logic [31:0] rd;             // last read word
  logic        er;             // last error flag
  int          errors;         // mismatches
  int          samples_checked; // comparisons
  int          n;              // wait counter
  logic [47:0] a_m = 48'h665544332211; // match entry
  logic [47:0] a_f = 48'h0A0B0C0D0E0F; // filter entry
  logic [47:0] a_x = 48'h123456789ABC; // invalid entry

  link_peer_model u_peer (.i_clock(i_clock), .o_tx_done(td),
    .o_collided(tc), .o_deferred(tf), .o_pause_sent(ps),
    .o_sent_time(pst), .o_pause_rcvd(pr), .o_rcvd_time(prt),
    .o_addr_stb(st), .o_dest(da));
  mac_pace_top #(.SLOT_CYC_SLOW(SLOW)) DUT (.i_clock(i_clock),
    .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_tx_done(td), .i_tx_collided(tc), .i_tx_deferred(tf),
    .i_pause_sent(ps), .i_pause_sent_time(pst), .i_pause_rcvd(pr),
    .i_pause_rcvd_time(prt), .i_rx_addr_stb(st), .i_rx_dest_addr(da),
    .o_long_gap(lg), .o_pacing_active(pa), .o_tx_enable(te),
    .o_send_pause(sp), .o_rx_valid(rv), .o_rx_hit(rh),
    .o_rx_accept(ra), .o_rx_channel(rc));

  // free running clock
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // compare one value
  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : check
  // final verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    pwdata <= ~d;
    if (n == 50) begin
      errors++;
      conclude();
    end
  endtask : apb
  // read and compare a register
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rchk
  // stage index and high word, commit with the low word
  task automatic put(input logic [4:0] i, input logic [47:0] a,
                     input logic v, m, input logic [2:0] c);
    apb(1'b1, OFS_INDEX, {27'h0, i});
    apb(1'b1, OFS_HI, {a[23:16], a[31:24], a[39:32], a[47:40]});
    apb(1'b1, OFS_LO, {11'h0, v, m, c, a[7:0], a[15:8]});
  endtask : put
  // one lookup and its outcome
  task automatic look(input logic [47:0] a, input logic h, m,
                      input logic [2:0] c);
    u_peer.dest(a);
    #1;
    check("rx_valid", {31'h0, rv}, 32'h1);
    check("rx_hit", {31'h0, rh}, {31'h0, h});
    check("rx_accept", {31'h0, ra}, {31'h0, m});
    check("rx_channel", {29'h0, rc}, {29'h0, c});
  endtask : look
  // count cycles until a flag rises, bounded
  task automatic wait_flag(input bit pick);
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while ((pick ? sp : te) !== 1'b1 && n < 400);
    if (n == 400) begin
      errors++;
      conclude();
    end
  endtask : wait_flag

  // main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    i_rst = 1'b1;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    rchk("pace", OFS_PACE, 32'h0);
    rchk("rxp", OFS_RXP, 32'h0);
    rchk("txp", OFS_TXP, 32'h0);
    rchk("ctrl", OFS_CTRL, 32'h2);
    check("tx_enable", {31'h0, te}, 32'h1);
    rchk("unmapped", 8'h1C, 32'h0);
    check("pslverr", {31'h0, er}, 32'h1);
    apb(1'b1, OFS_PACE, 32'h7);
    rchk("pace ro", OFS_PACE, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    $display("registers done");
    u_peer.frame(1'b1, 1'b0);
    #1;
    check("long_gap", {31'h0, lg}, 32'h0);
    check("pacing", {31'h0, pa}, 32'h1);
    u_peer.frame(1'b0, 1'b0);
    #1;
    check("long_gap", {31'h0, lg}, 32'h1);
    rchk("pace", OFS_PACE, 32'h1E);
    u_peer.frame(1'b0, 1'b1);
    #1;
    check("long_gap", {31'h0, lg}, 32'h0);
    rchk("pace", OFS_PACE, 32'h1F);
    for (int k = 30; k >= 0; k--) begin
      u_peer.frame(1'b0, 1'b0);
      rchk("pace", OFS_PACE, k);
    end
    u_peer.frame(1'b0, 1'b0);
    #1;
    check("long_gap", {31'h0, lg}, 32'h0);
    check("pacing", {31'h0, pa}, 32'h0);
    rchk("pace", OFS_PACE, 32'h0);
    $display("pacing done");
    // full pause frame loads rx countdown
    u_peer.sent(PAUSE_MAX);
    rchk("rxp", OFS_RXP, 32'hFF00);
    apb(1'b1, OFS_RXP, 32'hFFFF0005);
    u_peer.sent(16'h1234);
    rchk("rxp", OFS_RXP, 32'h5);
    apb(1'b1, OFS_RXP, 32'h2);
    wait_flag(1'b1);
    check("send gap", {31'h0, n > SLOW && n <= 2 * SLOW + 2}, 1);
    rchk("rxp", OFS_RXP, 32'h0);
    u_peer.sent(PAUSE_MAX);
    rchk("rxp", OFS_RXP, 32'hFF00);
    u_peer.rcvd(16'hABCD);
    #1;
    check("tx_enable", {31'h0, te}, 32'h0);
    rchk("txp", OFS_TXP, 32'hABCD);
    apb(1'b1, OFS_TXP, 32'h0);
    u_peer.rcvd(16'h0002);
    wait_flag(1'b0);
    check("pause len", {31'h0, n > SLOW && n <= 2 * SLOW + 3}, 1);
    rchk("txp", OFS_TXP, 32'h0);
    $display("pause done");
    for (int k = 0; k < ENTRIES; k++) put(k[4:0], 48'h0, 1'b0, 1'b0, 3'h0);
    put(5'd2, a_m, 1'b1, 1'b1, 3'h5);
    put(5'd3, a_f, 1'b1, 1'b0, 3'h6);
    put(5'd4, a_x, 1'b0, 1'b1, 3'h2);
    look(a_m, 1'b1, 1'b1, 3'h5);
    look(a_f, 1'b1, 1'b0, 3'h0);
    look(a_x, 1'b0, 1'b0, 3'h0);
    apb(1'b1, OFS_INDEX, 32'h2);
    apb(1'b1, OFS_HI, 32'hDEADBEEF);
    look(a_m, 1'b1, 1'b1, 3'h5);
    rchk("lo word", OFS_LO, 32'h001D1122);
    $display("address filter done");
    conclude();
  end
endmodule : mac_pace_top_tb
